// >>> core/tdp_port.sv
`timescale 1ns/1ns
//Operation
//- serial clock advances tap and shifts
//- serial clock resynchronised into core clock
//- one data line carries data and control
//- data sampled on serial clock fall
//- primary and secondary clock/data pin pairs
//- mode select chooses instruction or data path
//- debug segment decoded, only in debug mode
//- instruction shifted in, then handed to cpu in debug mode
//- instruction transfers are 32-bit groups
//- vendor tap with command and switch
//- vendor data shifts become device commands
//- command instruction persists across transfers
//- converter builds 4-wire signalling internally
//- cpu runs from 8 MHz oscillator
//- boot region decoded at its range
//- program region decoded at its range
//- page size per variant
//- row size per variant
//- last four boot words are config
//- flash controller does erase and program
//- mode select sampled on test clock rise
//- data out changes on test clock fall
//- data out driven only while shifting
`include "tdp_cfg.svh"
module tdp_port
   import tdp_pkg::*;
#(
   parameter bit BIG_FLASH = 1'b1
)(
   // clock and reset
   input  wire logic                   CLK,
   input  wire logic                   RESETN,
   // primary pin pair
   input  wire logic                   PRI_CLK_I,
   input  wire logic                   PRI_DATA_I,
   output logic                        PRI_DATA_O,
   output logic                        PRI_DATA_OE,
   // secondary pin pair
   input  wire logic                   SEC_CLK_I,
   input  wire logic                   SEC_DATA_I,
   output logic                        SEC_DATA_O,
   output logic                        SEC_DATA_OE,
   // pair select and cpu state
   input  wire logic                   USE_SECONDARY,
   input  wire logic                   CPU_DEBUG_MODE,
   // cpu instruction hand-off and address decode
   output logic [`TDP_WORD_W-1:0]      CPU_INSTR,
   output logic                        CPU_INSTR_VALID,
   input  wire logic [`TDP_WORD_W-1:0] CPU_DATA_OUT,
   input  wire logic [31:0]            CPU_ADDR,
   output logic                        DBGSEG_HIT,
   output logic                        BOOT_HIT,
   output logic                        PROG_HIT,
   output logic                        CFG_HIT,
   // vendor command and sizes to flash controller, cpu clock enable
   output logic [`TDP_VIR_W-1:0]       FLASH_CMD,
   output logic                        FLASH_CMD_VALID,
   output logic [10:0]                 PAGE_WORDS,
   output logic [7:0]                  ROW_WORDS,
   output logic                        CPU_CLK_EN
);
   // ******************************
   // pin sampling
   // ******************************
   logic p_clk, p_dat, s_clk, s_dat;
   tdp_sync u_pc (.CLK(CLK), .RESETN(RESETN), .d(PRI_CLK_I), .q(p_clk));
   tdp_sync u_pd (.CLK(CLK), .RESETN(RESETN), .d(PRI_DATA_I), .q(p_dat));
   tdp_sync u_sc (.CLK(CLK), .RESETN(RESETN), .d(SEC_CLK_I), .q(s_clk));
   tdp_sync u_sd (.CLK(CLK), .RESETN(RESETN), .d(SEC_DATA_I), .q(s_dat));

   logic sel_reg, pclk_q_reg;
   logic pclk, pdat, pclk_fall, pclk_rise;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sel_reg <= 1'b0;
      end else begin
         sel_reg <= USE_SECONDARY;
      end
   end
   assign pclk = sel_reg ? s_clk : p_clk;
   assign pdat = sel_reg ? s_dat : p_dat;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pclk_q_reg <= 1'b0;
      end else begin
         pclk_q_reg <= pclk;
      end
   end
   assign pclk_fall = pclk_q_reg & ~pclk;
   assign pclk_rise = ~pclk_q_reg & pclk;

   // ******************************
   // 2-wire to 4-wire converter
   // ******************************
   // each tap bit takes four serial clocks: tdi, tms, turnaround, tdo
   tdp_slot_type slot_reg;
   logic tdi_reg, tms_reg, tck_rise, tck_fall;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         slot_reg <= SL_TDI;
         tdi_reg  <= 1'b0;
         tms_reg  <= 1'b1;
      end else if (pclk_fall) begin
         unique case (slot_reg)
            SL_TDI:  tdi_reg <= pdat;
            SL_TMS:  tms_reg <= pdat;
            SL_TURN: ;
            SL_TDO:  ;
         endcase
         slot_reg <= tdp_slot_type'(slot_reg + 2'd1);
      end
   end
   // test clock rises after tms slot, falls at tdo slot
   // one cycle late so the tap steps on the tms bit taken at this fall,
   // not on the one left over from the previous tap bit
   logic tck_rise_reg;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tck_rise_reg <= 1'b0;
      end else begin
         tck_rise_reg <= pclk_fall & (slot_reg == SL_TMS);
      end
   end
   assign tck_rise = tck_rise_reg;
   assign tck_fall = pclk_rise & (slot_reg == SL_TDO);

   // ******************************
   // tap controllers
   // ******************************
   tdp_tapsel_type tsel_reg;
   tdp_tap_type cst, vst;
   // no test reset pin on the 2-wire side: taps clear on core reset or on tms held high
   // both machines see the same tms; only the selected one shifts
   tdp_tap u_ctap (.CLK(CLK), .RESETN(RESETN), .tck_rise(tck_rise),
                   .tms(tms_reg), .trst(1'b0), .state(cst));
   tdp_tap u_vtap (.CLK(CLK), .RESETN(RESETN), .tck_rise(tck_rise),
                   .tms(tms_reg), .trst(1'b0), .state(vst));

   logic [`TDP_IR_W-1:0]   cir_sh_reg, cir_reg;
   logic [`TDP_VIR_W-1:0]  vir_sh_reg, vir_reg;
   logic [`TDP_WORD_W-1:0] cdr_reg, vdr_reg;
   tdp_tap_type st;
   assign st = (tsel_reg == TS_CPU) ? cst : vst;

   // cpu tap: instruction and data registers
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cir_sh_reg <= '0;
         cir_reg    <= `TDP_IR_DATA;
         cdr_reg    <= '0;
      end else if (tck_rise && tsel_reg == TS_CPU) begin
         unique case (cst)
            TL_RESET:  cir_reg <= `TDP_IR_DATA;
            TL_CAP_IR: cir_sh_reg <= `TDP_IR_W'h01;
            TL_SH_IR:  cir_sh_reg <= {tdi_reg, cir_sh_reg[`TDP_IR_W-1:1]};
            TL_UPD_IR: cir_reg <= cir_sh_reg;
            TL_CAP_DR: cdr_reg <= CPU_DATA_OUT;
            TL_SH_DR:  cdr_reg <= {tdi_reg, cdr_reg[`TDP_WORD_W-1:1]};
            default: ;
         endcase
      end
   end
   // vendor tap
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         vir_sh_reg <= '0;
         vir_reg    <= `TDP_VIR_COMMAND;
         vdr_reg    <= '0;
      end else if (tck_rise && tsel_reg == TS_VEND) begin
         unique case (vst)
            TL_RESET:  vir_reg <= `TDP_VIR_COMMAND;
            TL_CAP_IR: vir_sh_reg <= `TDP_VIR_W'h01;
            TL_SH_IR:  vir_sh_reg <= {tdi_reg, vir_sh_reg[`TDP_VIR_W-1:1]};
            TL_UPD_IR: vir_reg <= vir_sh_reg;
            TL_CAP_DR: vdr_reg <= '0;
            TL_SH_DR:  vdr_reg <= {tdi_reg, vdr_reg[`TDP_WORD_W-1:1]};
            default: ;
         endcase
      end
   end
   // tap switch: held until the other tap's switch instruction
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tsel_reg <= TS_VEND;
      end else if (tck_rise && vst == TL_UPD_IR && tsel_reg == TS_VEND) begin
         if (vir_sh_reg == `TDP_VIR_SW_CPU) begin
            tsel_reg <= TS_CPU;
         end
      end else if (tck_rise && cst == TL_UPD_IR && tsel_reg == TS_CPU) begin
         if (cir_sh_reg == `TDP_IR_W'(`TDP_VIR_SW_VEND)) begin
            tsel_reg <= TS_VEND;
         end
      end
   end

   // ******************************
   // cpu and flash hand-off
   // ******************************
   logic shift_upd;
   assign shift_upd = tck_rise & (st == TL_UPD_DR);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         CPU_INSTR       <= '0;
         CPU_INSTR_VALID <= 1'b0;
      end else begin
         CPU_INSTR_VALID <= 1'b0;
         if (shift_upd && tsel_reg == TS_CPU && cir_reg == `TDP_IR_DATA
             && CPU_DEBUG_MODE) begin
            CPU_INSTR       <= cdr_reg;
            CPU_INSTR_VALID <= 1'b1;
         end
      end
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         FLASH_CMD       <= '0;
         FLASH_CMD_VALID <= 1'b0;
      end else begin
         FLASH_CMD_VALID <= 1'b0;
         if (shift_upd && tsel_reg == TS_VEND
             && vir_reg == `TDP_VIR_COMMAND) begin
            FLASH_CMD       <= vdr_reg[`TDP_WORD_W-1 -: `TDP_VIR_W];
            FLASH_CMD_VALID <= 1'b1;
         end
      end
   end
   // address decode
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         DBGSEG_HIT <= 1'b0;
         BOOT_HIT   <= 1'b0;
         PROG_HIT   <= 1'b0;
         CFG_HIT    <= 1'b0;
         PAGE_WORDS <= '0;
         ROW_WORDS  <= '0;
      end else begin
         DBGSEG_HIT <= CPU_DEBUG_MODE && CPU_ADDR >= `TDP_DBGSEG_BASE
                       && CPU_ADDR <= `TDP_DBGSEG_LAST;
         BOOT_HIT   <= CPU_ADDR >= `TDP_BOOT_BASE
                       && CPU_ADDR <= `TDP_BOOT_LAST;
         PROG_HIT   <= CPU_ADDR >= `TDP_PROG_BASE
                       && CPU_ADDR <= `TDP_PROG_LAST;
         CFG_HIT    <= CPU_ADDR >= `TDP_CFG_BASE
                       && CPU_ADDR <= `TDP_BOOT_LAST;
         PAGE_WORDS <= BIG_FLASH ? 11'(`TDP_PAGE_BIG)
                                 : 11'(`TDP_PAGE_SMALL);
         ROW_WORDS  <= BIG_FLASH ? 8'(`TDP_ROW_BIG)
                                 : 8'(`TDP_ROW_SMALL);
      end
   end

   // ******************************
   // cpu clock enable
   // ******************************
   localparam int CPU_DIV = 100000000 / `TDP_CPU_HZ;
   logic [4:0] div_reg;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         div_reg    <= '0;
         CPU_CLK_EN <= 1'b0;
      end else begin
         CPU_CLK_EN <= (div_reg == 5'(CPU_DIV - 1));
         div_reg    <= (div_reg == 5'(CPU_DIV - 1)) ? 5'h00 : div_reg + 5'h01;
      end
   end

   // ******************************
   // data out on the line
   // ******************************
   logic tdo_bit, tdo_en;
   always_comb begin
      tdo_bit = 1'b0;
      tdo_en  = 1'b0;
      if (st == TL_SH_DR) begin
         tdo_en  = 1'b1;
         tdo_bit = (tsel_reg == TS_CPU) ? cdr_reg[0] : vdr_reg[0];
      end else if (st == TL_SH_IR) begin
         tdo_en  = 1'b1;
         tdo_bit = (tsel_reg == TS_CPU) ? cir_sh_reg[0] : vir_sh_reg[0];
      end
   end
   logic tdo_reg, tdo_en_reg;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tdo_reg    <= 1'b0;
         tdo_en_reg <= 1'b0;
      end else if (tck_fall) begin
         tdo_reg    <= tdo_bit;
         tdo_en_reg <= tdo_en;
      end else if (pclk_fall && slot_reg == SL_TDO) begin
         tdo_en_reg <= 1'b0;
      end
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRI_DATA_O  <= 1'b0;
         PRI_DATA_OE <= 1'b0;
         SEC_DATA_O  <= 1'b0;
         SEC_DATA_OE <= 1'b0;
      end else begin
         PRI_DATA_O  <= tdo_reg;
         SEC_DATA_O  <= tdo_reg;
         PRI_DATA_OE <= tdo_en_reg & ~sel_reg;
         SEC_DATA_OE <= tdo_en_reg & sel_reg;
      end
   end
endmodule : tdp_port

// >>> inc/tdp_cfg.svh
`ifndef TDP_CFG_SVH
`define TDP_CFG_SVH
// address map
`define TDP_DBGSEG_BASE   32'hFF200000
`define TDP_DBGSEG_LAST   32'hFF2FFFFF
`define TDP_BOOT_BASE     32'h1FC00000
`define TDP_BOOT_LAST     32'h1FC02FFF
`define TDP_PROG_BASE     32'h1D000000
`define TDP_PROG_LAST     32'h1D07FFFF
// config words: last four words of boot region
`define TDP_CFG_BASE      32'h1FC02FF0
// page and row sizes in instruction words
`define TDP_PAGE_BIG      1024
`define TDP_PAGE_SMALL    256
`define TDP_ROW_BIG       128
`define TDP_ROW_SMALL     32
// widths
`define TDP_WORD_W        32
`define TDP_IR_W          5
`define TDP_VIR_W         8
// instruction codes
`define TDP_IR_DATA       5'h09
`define TDP_IR_ADDR       5'h08
`define TDP_IR_CTRL       5'h0A
`define TDP_VIR_COMMAND   8'h07
`define TDP_VIR_SW_CPU    8'h05
`define TDP_VIR_SW_VEND   8'h04
// cpu clock
`define TDP_CPU_HZ        8000000
`endif

// >>> inc/tdp_pkg.sv
package tdp_pkg;
   typedef enum logic [3:0] {
      TL_RESET, TL_IDLE, TL_SEL_DR, TL_CAP_DR, TL_SH_DR, TL_EX1_DR,
      TL_PAU_DR, TL_EX2_DR, TL_UPD_DR, TL_SEL_IR, TL_CAP_IR, TL_SH_IR,
      TL_EX1_IR, TL_PAU_IR, TL_EX2_IR, TL_UPD_IR
   } tdp_tap_type;
   // 2-wire to 4-wire slot within a bit group
   typedef enum logic [1:0] {
      SL_TDI, SL_TMS, SL_TURN, SL_TDO
   } tdp_slot_type;
   typedef enum logic {
      TS_CPU, TS_VEND
   } tdp_tapsel_type;
endpackage : tdp_pkg

// >>> core/tdp_sync.sv
`timescale 1ns/1ns
module tdp_sync (
   // clock and reset
   input  wire logic CLK,
   input  wire logic RESETN,
   // level
   input  wire logic d,
   output logic      q
);
   logic s1_reg;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s1_reg <= 1'b0;
         q      <= 1'b0;
      end else begin
         s1_reg <= d;
         q      <= s1_reg;
      end
   end
endmodule : tdp_sync

// >>> core/tdp_tap.sv
`timescale 1ns/1ns
// generic tap state machine advanced by a clock-enable pulse
module tdp_tap
   import tdp_pkg::*;
(
   // clock and reset
   input  wire logic  CLK,
   input  wire logic  RESETN,
   // 4-wire side
   input  wire logic  tck_rise,
   input  wire logic  tms,
   input  wire logic  trst,
   output tdp_tap_type state
);
   tdp_tap_type state_next;
   always_comb begin
      state_next = state;
      unique case (state)
         TL_RESET:  state_next = tms ? TL_RESET  : TL_IDLE;
         TL_IDLE:   state_next = tms ? TL_SEL_DR : TL_IDLE;
         TL_SEL_DR: state_next = tms ? TL_SEL_IR : TL_CAP_DR;
         TL_CAP_DR: state_next = tms ? TL_EX1_DR : TL_SH_DR;
         TL_SH_DR:  state_next = tms ? TL_EX1_DR : TL_SH_DR;
         TL_EX1_DR: state_next = tms ? TL_UPD_DR : TL_PAU_DR;
         TL_PAU_DR: state_next = tms ? TL_EX2_DR : TL_PAU_DR;
         TL_EX2_DR: state_next = tms ? TL_UPD_DR : TL_SH_DR;
         TL_UPD_DR: state_next = tms ? TL_SEL_DR : TL_IDLE;
         TL_SEL_IR: state_next = tms ? TL_RESET  : TL_CAP_IR;
         TL_CAP_IR: state_next = tms ? TL_EX1_IR : TL_SH_IR;
         TL_SH_IR:  state_next = tms ? TL_EX1_IR : TL_SH_IR;
         TL_EX1_IR: state_next = tms ? TL_UPD_IR : TL_PAU_IR;
         TL_PAU_IR: state_next = tms ? TL_EX2_IR : TL_PAU_IR;
         TL_EX2_IR: state_next = tms ? TL_UPD_IR : TL_SH_IR;
         TL_UPD_IR: state_next = tms ? TL_SEL_DR : TL_IDLE;
      endcase
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= TL_RESET;
      end else if (trst) begin
         state <= TL_RESET;
      end else if (tck_rise) begin
         state <= state_next;
      end
   end
endmodule : tdp_tap

// >>> tb/tdp_port_checker.sv
`timescale 1ns/1ns
`include "tdp_cfg.svh"
module tdp_port_checker #(
   parameter bit BIG_FLASH = 1'b1
)(
   // clock and reset
   input wire logic        CLK,
   input wire logic        RESETN,
   // data pins
   input wire logic        PRI_DATA_O,
   input wire logic        PRI_DATA_OE,
   input wire logic        SEC_DATA_OE,
   // cpu side
   input wire logic        CPU_DEBUG_MODE,
   input wire logic [31:0] CPU_ADDR,
   input wire logic        DBGSEG_HIT,
   input wire logic        BOOT_HIT,
   input wire logic        PROG_HIT,
   input wire logic        CFG_HIT,
   input wire logic        CPU_INSTR_VALID,
   input wire logic        CPU_CLK_EN,
   // flash side
   input wire logic        FLASH_CMD_VALID,
   input wire logic [10:0] PAGE_WORDS,
   input wire logic [7:0]  ROW_WORDS
);
   // ****
   // decode, pulse and pin checks
   // ****
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   function automatic logic inr(logic [31:0] a, lo, hi);
      return a >= lo && a <= hi;
   endfunction : inr
   dbg_decode_a: assert property ($past(RESETN) |->
      DBGSEG_HIT == ($past(CPU_DEBUG_MODE) &&
      inr($past(CPU_ADDR), `TDP_DBGSEG_BASE, `TDP_DBGSEG_LAST)))
      else $error("debug segment hit wrong");
   boot_decode_a: assert property ($past(RESETN) |->
      BOOT_HIT == inr($past(CPU_ADDR), `TDP_BOOT_BASE, `TDP_BOOT_LAST))
      else $error("boot hit wrong");
   prog_decode_a: assert property ($past(RESETN) |->
      PROG_HIT == inr($past(CPU_ADDR), `TDP_PROG_BASE, `TDP_PROG_LAST))
      else $error("program hit wrong");
   cfg_decode_a: assert property ($past(RESETN) |->
      CFG_HIT == inr($past(CPU_ADDR), `TDP_CFG_BASE, `TDP_BOOT_LAST))
      else $error("config hit wrong");
   page_size_a: assert property ($past(RESETN) |->
      PAGE_WORDS == (BIG_FLASH ? 11'h400 : 11'h100))
      else $error("page size wrong");
   row_size_a: assert property ($past(RESETN) |->
      ROW_WORDS == (BIG_FLASH ? 8'h80 : 8'h20))
      else $error("row size wrong");
   tick_gap_a: assert property (CPU_CLK_EN |=> !CPU_CLK_EN [*8])
      else $error("cpu tick too soon");
   tick_period_a: assert property (CPU_CLK_EN |-> ##12 CPU_CLK_EN)
      else $error("cpu tick period wrong");
   cmd_pulse_a: assert property (FLASH_CMD_VALID |=> !FLASH_CMD_VALID)
      else $error("command strobe too long");
   instr_pulse_a: assert property (CPU_INSTR_VALID |=> !CPU_INSTR_VALID)
      else $error("instruction strobe too long");
   one_pair_a: assert property (!(PRI_DATA_OE && SEC_DATA_OE))
      else $error("both pairs driven");
   tdo_hold_a: assert property (PRI_DATA_OE && $past(PRI_DATA_OE)
      |-> $stable(PRI_DATA_O))
      else $error("data out moved while driven");
endmodule : tdp_port_checker
bind tdp_port tdp_port_checker #(.BIG_FLASH(BIG_FLASH)) chk (
   .CLK(CLK), .RESETN(RESETN), .PRI_DATA_O(PRI_DATA_O),
   .PRI_DATA_OE(PRI_DATA_OE), .SEC_DATA_OE(SEC_DATA_OE),
   .CPU_DEBUG_MODE(CPU_DEBUG_MODE), .CPU_ADDR(CPU_ADDR),
   .DBGSEG_HIT(DBGSEG_HIT), .BOOT_HIT(BOOT_HIT), .PROG_HIT(PROG_HIT),
   .CFG_HIT(CFG_HIT), .CPU_INSTR_VALID(CPU_INSTR_VALID),
   .CPU_CLK_EN(CPU_CLK_EN), .FLASH_CMD_VALID(FLASH_CMD_VALID),
   .PAGE_WORDS(PAGE_WORDS), .ROW_WORDS(ROW_WORDS));

// >>> tb/tdp_prog_model.sv
`timescale 1ns/1ns
module tdp_prog_model (
   // serial pins toward device
   output logic      prog_serial_clock,
   output logic      host_data,
   output logic      host_oe,
   // resolved line level
   input  wire logic line
);
   // ****
   // probe driving four slots per tap bit
   // ****
   initial begin
      prog_serial_clock = 1'b0;
      host_data = 1'b1;
      host_oe = 1'b0;
   end
   // clock stands low between slots and frames
   task automatic slot(input logic d, input logic drv);
      #20 host_data = d;
      host_oe = drv;
      #20 prog_serial_clock = 1'b1;
      #40 prog_serial_clock = 1'b0;
   endtask : slot
   // extra wait keeps us off the line until the device lets go
   task automatic tap_bit(input logic tdi, tms, output logic tdo);
      slot(tdi, 1'b1);
      slot(tms, 1'b1);
      slot(1'b1, 1'b0);
      slot(1'b1, 1'b0);
      #10 tdo = line;
      #30;
   endtask : tap_bit
   // whole register scan from idle back to idle, lsb first
   task automatic xfer(input bit ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic t;
      dout = '0;
      tap_bit(1'b0, 1'b1, t);
      if (ir) tap_bit(1'b0, 1'b1, t);
      tap_bit(1'b0, 1'b0, t);
      tap_bit(1'b0, 1'b0, t);
      dout = {t, dout[31:1]};
      for (int i = 0; i < n; i++) begin
         tap_bit(din[i], i == n - 1, t);
         if (i < n - 1) dout = {t, dout[31:1]};
      end
      tap_bit(1'b0, 1'b1, t);
      tap_bit(1'b0, 1'b0, t);
   endtask : xfer
endmodule : tdp_prog_model

// >>> tb/tdp_port_tb.sv
`timescale 1ns/1ns
`include "tdp_cfg.svh"
module tdp_port_tb;
   import tdp_pkg::*;
   // ****
   // bench signals
   // ****
   logic        clk, resetn, use_sec, dbg;
   logic [31:0] addr, cdata, cpu_instr, ins_seen, w, ins;
   logic [7:0]  flash_cmd, cmd_seen, c;
   logic [10:0] page_w;
   logic [7:0]  row_w;
   logic        pri_o, pri_oe, sec_o, sec_oe, ivld, cvld, cpu_en, t;
   logic        dhit, bhit, phit, fhit;
   int          bad_count, samples_checked, cmd_n, ins_n, cycles;
   logic [31:0] corner [12] = '{32'hFF200000, 32'hFF2FFFFF, 32'hFF300000,
      32'h1FC00000, 32'h1FC02FEC, 32'h1FC02FF0, 32'h1FC02FFF, 32'h1FC03000,
      32'h1D000000, 32'h1D07FFFF, 32'h1D080000, 32'h1CFFFFFF};
   wire pclk, hdat, hoe;
   // released pins float high through the pull-up
   wire pri_lvl = pri_oe ? pri_o : (!use_sec && hoe) ? hdat : 1'b1;
   wire sec_lvl = sec_oe ? sec_o : (use_sec && hoe) ? hdat : 1'b1;
   wire line = use_sec ? sec_lvl : pri_lvl;
   tdp_prog_model prog (.prog_serial_clock(pclk), .host_data(hdat),
      .host_oe(hoe), .line(line));
   tdp_port #(.BIG_FLASH(1'b1)) dut (.CLK(clk), .RESETN(resetn),
      .PRI_CLK_I(pclk & !use_sec), .PRI_DATA_I(pri_lvl),
      .PRI_DATA_O(pri_o), .PRI_DATA_OE(pri_oe),
      .SEC_CLK_I(pclk & use_sec), .SEC_DATA_I(sec_lvl),
      .SEC_DATA_O(sec_o), .SEC_DATA_OE(sec_oe), .USE_SECONDARY(use_sec),
      .CPU_DEBUG_MODE(dbg), .CPU_INSTR(cpu_instr), .CPU_INSTR_VALID(ivld),
      .CPU_DATA_OUT(cdata), .CPU_ADDR(addr), .DBGSEG_HIT(dhit),
      .BOOT_HIT(bhit), .PROG_HIT(phit), .CFG_HIT(fhit),
      .FLASH_CMD(flash_cmd), .FLASH_CMD_VALID(cvld), .PAGE_WORDS(page_w),
      .ROW_WORDS(row_w), .CPU_CLK_EN(cpu_en));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         report_and_stop();
      end
      if (cvld === 1'b1) begin
         cmd_seen <= flash_cmd;
         cmd_n <= cmd_n + 1;
      end
      if (ivld === 1'b1) begin
         ins_seen <= cpu_instr;
         ins_n <= ins_n + 1;
      end
   end
   // ****
   // checking helpers
   // ****
   task automatic cmp_word(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word
   function automatic logic [3:0] hits(logic [31:0] a, logic d);
      return {d && a >= `TDP_DBGSEG_BASE && a <= `TDP_DBGSEG_LAST,
         a >= `TDP_BOOT_BASE && a <= `TDP_BOOT_LAST,
         a >= `TDP_PROG_BASE && a <= `TDP_PROG_LAST,
         a >= `TDP_CFG_BASE && a <= `TDP_BOOT_LAST};
   endfunction : hits
   task automatic decode(input logic [31:0] a, input logic d);
      @(posedge clk);
      addr <= a;
      dbg <= d;
      @(posedge clk);
      @(negedge clk);
      cmp_word("hits", hits(a, d), {dhit, bhit, phit, fhit});
   endtask : decode
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // ****
   // main sequence
   // ****
   initial begin
      {clk, resetn, use_sec, dbg, addr, cdata} = '0;
      {bad_count, samples_checked, cmd_n, ins_n, cycles} = '0;
      void'($urandom(32'h0D6D));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      cmp_word("page", 32'h400, page_w);
      cmp_word("row", 32'h80, row_w);
      foreach (corner[i]) decode(corner[i], i % 2 == 0);
      repeat (40) decode(corner[$urandom_range(11)] + $urandom_range(31)
         - 16, $urandom_range(1));
      prog.tap_bit(1'b0, 1'b0, t);
      prog.xfer(1'b1, 8, `TDP_VIR_COMMAND, w);
      cmp_word("cmds after ir", 0, cmd_n);
      for (int k = 1; k <= 2; k++) begin
         c = $urandom;
         prog.xfer(1'b0, 32, {c, 24'($urandom)}, w);
         cmp_word("command", c, cmd_seen);
         cmp_word("command count", k, cmd_n);
      end
      prog.xfer(1'b1, 8, `TDP_VIR_SW_CPU, w);
      @(posedge clk);
      use_sec <= 1'b1;
      dbg <= 1'b1;
      cdata <= $urandom;
      ins = $urandom;
      repeat (4) @(posedge clk);
      prog.xfer(1'b0, 32, ins, w);
      cmp_word("instruction", ins, ins_seen);
      cmp_word("instr count", 1, ins_n);
      cmp_word("cpu word out", cdata, w);
      cmp_word("cmds after cpu", 2, cmd_n);
      dbg <= 1'b0;
      @(posedge clk);
      prog.xfer(1'b0, 32, $urandom, w);
      cmp_word("refused instr", 1, ins_n);
      prog.xfer(1'b1, 5, `TDP_VIR_SW_VEND, w);
      prog.xfer(1'b1, 8, `TDP_VIR_COMMAND, w);
      c = $urandom;
      prog.xfer(1'b0, 32, {c, 24'($urandom)}, w);
      cmp_word("command back", c, cmd_seen);
      cmp_word("command total", 3, cmd_n);
      cmp_word("oe idle", 0, {pri_oe, sec_oe});
      report_and_stop();
   end
endmodule : tdp_port_tb
